// ===== verilog/amp_ctrl_regs.sv
/*
 * Amplifier control register bank behind an AHB-Lite slave port.
 * Three byte-wide control registers plus one read-only power status.
 * Assumes one AHB-Lite master, single word transfers, CLK at 100 MHz,
 * and a processor power mode code synchronous to CLK.
 */
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - Three RW byte registers at 0, 1, 2
// - Enable bit 7 powers the amplifier
// - Deepest two stop modes force amplifier off
// - Bit 6: 0 high speed, 1 low power
// - Mode bits 1:0 select configuration
// - Gain codes in 4:2 and 1:0, reset zero
// - Positive selector bits 6:4 routes source
// - Negative selector bits 2:0, same codes
// - Selectors reset to external pins
// - Wait and stop3 off when enable low
module amp_ctrl_regs
    import amp_ctrl_pkg::*;
#(
    parameter int ADDR_W = ADDR_WIDTH
)
(
    input  wire logic              CLK,
    input  wire logic              RST,
    input  wire logic              HSEL,
    input  wire logic [ADDR_W-1:0] HADDR,
    input  wire logic [1:0]        HTRANS,
    input  wire logic              HWRITE,
    input  wire logic [2:0]        HSIZE,
    input  wire logic [31:0]       HWDATA,
    input  wire logic              HREADY,
    input  wire logic [2:0]        POWER_MODE,
    output var  logic [31:0]       HRDATA,
    output var  logic              HREADYOUT,
    output var  logic              HRESP,
    output var  logic              AMP_POWER_ON,
    output var  logic              AMP_HIGH_SPEED,
    output var  logic              AMP_BUFFER_ON,
    output var  logic              AMP_GENERAL_ON,
    output var  logic              AMP_PGA_ON,
    output var  logic              AMP_PGA_INVERTING,
    output var  logic [2:0]        FEEDBACK_RESISTOR_CODE,
    output var  logic [1:0]        INPUT_RESISTOR_CODE,
    output var  logic [7:0]        POS_SWITCH,
    output var  logic [7:0]        NEG_SWITCH
);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [7:0]        amp_enable_mode_control;
    logic [7:0]        amp_gain_resistor_select;
    logic [7:0]        amp_input_select;
    logic [7:0]        next_amp_enable_mode_control;
    logic [7:0]        next_amp_gain_resistor_select;
    logic [7:0]        next_amp_input_select;
    logic              wr_pending;
    logic [7:0]        wr_index;
    logic              next_wr_pending;
    logic [7:0]        next_wr_index;
    logic [31:0]       next_hrdata;
    logic              take;
    logic [7:0]        addr_index;
    logic              word_ok;
    logic              amp_enable;
    logic              low_power_select;
    logic [1:0]        amp_mode;
    logic [2:0]        positive_input_select;
    logic [2:0]        negative_input_select;
    logic [2:0]        feedback_resistor_code;
    logic [1:0]        input_resistor_code;

    // Index of a word address; upper address bits above the map alias off
    function automatic logic [7:0] word_index(input logic [ADDR_W-1:0] a);
        return a[9:2];
    endfunction

    // ------------------------------------------------------------------
    // Field views of the stored registers
    // ------------------------------------------------------------------
    assign amp_enable            = amp_enable_mode_control[ENABLE_BIT];
    assign low_power_select      = amp_enable_mode_control[LOW_POWER_BIT];
    assign amp_mode              = amp_enable_mode_control[MODE_LSB +: 2];
    assign feedback_resistor_code =
        amp_gain_resistor_select[FEEDBACK_LSB +: 3];
    assign input_resistor_code   =
        amp_gain_resistor_select[INPUT_RES_LSB +: 2];
    assign positive_input_select = amp_input_select[POS_SEL_LSB +: 3];
    assign negative_input_select = amp_input_select[NEG_SEL_LSB +: 3];

    // ------------------------------------------------------------------
    // Address phase decode
    // ------------------------------------------------------------------
    assign addr_index = word_index(HADDR);
    assign word_ok    = (HADDR[1:0] == 2'b00) && (HSIZE == 3'h2);
    assign take       = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ)
                        && word_ok;

    // Capture write address phase; read data is prepared here
    always_comb begin
        next_wr_pending = take && HWRITE;
        next_wr_index   = take ? addr_index : wr_index;
        next_hrdata     = HRDATA;
        if (take && !HWRITE) begin
            next_hrdata = 32'h0000_0000;
            unique case (addr_index)
                IDX_ENABLE_MODE: next_hrdata[7:0] =
                    amp_enable_mode_control;
                IDX_GAIN:        next_hrdata[7:0] =
                    amp_gain_resistor_select;
                IDX_INPUT:       next_hrdata[7:0] =
                    amp_input_select;
                IDX_POWER_STAT:  next_hrdata[0]   = AMP_POWER_ON;
                default:         next_hrdata      = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            wr_pending <= 1'b0;
            wr_index   <= 8'h00;
            HRDATA     <= 32'h0000_0000;
        end else begin
            wr_pending <= next_wr_pending;
            wr_index   <= next_wr_index;
            HRDATA     <= next_hrdata;
        end
    end

    // ------------------------------------------------------------------
    // Data phase write into the registers
    // ------------------------------------------------------------------
    always_comb begin
        next_amp_enable_mode_control  = amp_enable_mode_control;
        next_amp_gain_resistor_select = amp_gain_resistor_select;
        next_amp_input_select         = amp_input_select;
        if (wr_pending) begin
            unique case (wr_index)
                IDX_ENABLE_MODE: next_amp_enable_mode_control =
                    HWDATA[7:0] & MASK_ENABLE_MODE;
                IDX_GAIN:        next_amp_gain_resistor_select =
                    HWDATA[7:0] & MASK_GAIN;
                IDX_INPUT:       next_amp_input_select =
                    HWDATA[7:0] & MASK_INPUT;
                default:         ;
            endcase
        end
    end

    // Registers reset to zero: off, buffer, external pins
    always_ff @(posedge CLK) begin
        if (RST) begin
            amp_enable_mode_control  <= RESET_ENABLE_MODE;
            amp_gain_resistor_select <= RESET_GAIN;
            amp_input_select         <= RESET_INPUT;
        end else begin
            amp_enable_mode_control  <= next_amp_enable_mode_control;
            amp_gain_resistor_select <= next_amp_gain_resistor_select;
            amp_input_select         <= next_amp_input_select;
        end
    end

    // ------------------------------------------------------------------
    // Bus answer: zero wait state, always OKAY
    // ------------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
        end else begin
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Gain codes pass straight to the resistor ladder
    // ------------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            FEEDBACK_RESISTOR_CODE <= 3'h0;
            INPUT_RESISTOR_CODE    <= 2'h0;
        end else begin
            FEEDBACK_RESISTOR_CODE <= feedback_resistor_code;
            INPUT_RESISTOR_CODE    <= input_resistor_code;
        end
    end

    // ------------------------------------------------------------------
    // Switch decode; wait and stop3 follow the enable bit alone
    // ------------------------------------------------------------------
    amp_switch_decode u_decode (
        .clk           (CLK),
        .rst           (RST),
        .enable        (amp_enable),
        .low_power     (low_power_select),
        .mode          (amp_mode),
        .pos_code      (positive_input_select),
        .neg_code      (negative_input_select),
        .power_mode    (POWER_MODE),
        .power_on      (AMP_POWER_ON),
        .high_speed    (AMP_HIGH_SPEED),
        .buffer_on     (AMP_BUFFER_ON),
        .general_on    (AMP_GENERAL_ON),
        .pga_on        (AMP_PGA_ON),
        .pga_inverting (AMP_PGA_INVERTING),
        .pos_switch    (POS_SWITCH),
        .neg_switch    (NEG_SWITCH)
    );

endmodule // amp_ctrl_regs

`default_nettype wire

// ===== verilog/amp_ctrl_pkg.sv
/*
 * Package for the amplifier control register bank: offsets, field
 * positions, reset values and input source encodings.
 * Assumes an AHB-Lite slave with 32-bit data, one register per word.
 */
package amp_ctrl_pkg;

    // ------------------------------------------------------------------
    // Register indices and address width
    // ------------------------------------------------------------------
    localparam logic [7:0]  IDX_ENABLE_MODE = 8'h00;
    localparam logic [7:0]  IDX_GAIN        = 8'h01;
    localparam logic [7:0]  IDX_INPUT       = 8'h02;
    localparam logic [7:0]  IDX_POWER_STAT  = 8'h03;
    localparam int          ADDR_WIDTH      = 12;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int          ENABLE_BIT      = 7;
    localparam int          LOW_POWER_BIT   = 6;
    localparam int          MODE_LSB        = 0;
    localparam int          FEEDBACK_LSB    = 2;
    localparam int          INPUT_RES_LSB   = 0;
    localparam int          POS_SEL_LSB     = 4;
    localparam int          NEG_SEL_LSB     = 0;

    // ------------------------------------------------------------------
    // Writable bit masks and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]  MASK_ENABLE_MODE = 8'hC3;
    localparam logic [7:0]  MASK_GAIN        = 8'h1F;
    localparam logic [7:0]  MASK_INPUT       = 8'h77;
    localparam logic [7:0]  RESET_ENABLE_MODE = 8'h00;
    localparam logic [7:0]  RESET_GAIN        = 8'h00;
    localparam logic [7:0]  RESET_INPUT       = 8'h00;

    // ------------------------------------------------------------------
    // Configuration modes
    // ------------------------------------------------------------------
    localparam logic [1:0]  MODE_BUFFER      = 2'h0;
    localparam logic [1:0]  MODE_INVERTING   = 2'h1;
    localparam logic [1:0]  MODE_GENERAL     = 2'h2;
    localparam logic [1:0]  MODE_NONINVERT   = 2'h3;

    // ------------------------------------------------------------------
    // Input source codes and one-hot switch positions
    // ------------------------------------------------------------------
    localparam logic [2:0]  SRC_EXTERNAL     = 3'h0;
    localparam logic [2:0]  SRC_FIRST_AMP    = 3'h1;
    localparam logic [2:0]  SRC_SECOND_AMP   = 3'h2;
    localparam logic [2:0]  SRC_RESERVED     = 3'h3;
    localparam logic [2:0]  SRC_COARSE_DAC   = 3'h4;
    localparam logic [2:0]  SRC_FINE_DAC     = 3'h5;
    localparam logic [2:0]  SRC_SUPPLY       = 3'h6;
    localparam logic [2:0]  SRC_GROUND       = 3'h7;

    // ------------------------------------------------------------------
    // Processor power modes
    // ------------------------------------------------------------------
    localparam logic [2:0]  PM_RUN           = 3'h0;
    localparam logic [2:0]  PM_WAIT          = 3'h1;
    localparam logic [2:0]  PM_STOP3         = 3'h2;
    localparam logic [2:0]  PM_STOP2         = 3'h3;
    localparam logic [2:0]  PM_STOP1         = 3'h4;

    // AHB-Lite transfer type for a single transfer
    localparam logic [1:0]  HTRANS_NONSEQ    = 2'h2;

    // Decode of a source code to a one-hot switch set; reserved opens all
    function automatic logic [7:0] source_switches(input logic [2:0] code);
        logic [7:0] sw;
        sw = 8'h00;
        if (code != SRC_RESERVED) begin
            sw[code] = 1'b1;
        end
        return sw;
    endfunction

endpackage : amp_ctrl_pkg

// ===== verilog/amp_switch_decode.sv
/*
 * Decodes stored control fields into amplifier switch controls.
 * Assumes synchronous inputs on CLK; all outputs are registered.
 */
`timescale 1ns/10ps
`default_nettype none

module amp_switch_decode
    import amp_ctrl_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       enable,
    input  wire logic       low_power,
    input  wire logic [1:0] mode,
    input  wire logic [2:0] pos_code,
    input  wire logic [2:0] neg_code,
    input  wire logic [2:0] power_mode,
    output var  logic       power_on,
    output var  logic       high_speed,
    output var  logic       buffer_on,
    output var  logic       general_on,
    output var  logic       pga_on,
    output var  logic       pga_inverting,
    output var  logic [7:0] pos_switch,
    output var  logic [7:0] neg_switch
);

    logic       next_power_on;
    logic       next_high_speed;
    logic       next_buffer_on;
    logic       next_general_on;
    logic       next_pga_on;
    logic       next_pga_inverting;
    logic [7:0] next_pos_switch;
    logic [7:0] next_neg_switch;
    logic       deep_stop;

    // ------------------------------------------------------------------
    // Next switch state
    // ------------------------------------------------------------------
    always_comb begin
        deep_stop = (power_mode == PM_STOP1) || (power_mode == PM_STOP2);
        next_power_on      = enable && !deep_stop;
        next_high_speed    = next_power_on && !low_power;
        next_buffer_on     = next_power_on && (mode == MODE_BUFFER);
        next_general_on    = next_power_on && (mode == MODE_GENERAL);
        next_pga_on        = next_power_on && mode[0];
        next_pga_inverting = next_power_on && (mode == MODE_INVERTING);
        next_pos_switch    = next_power_on ? source_switches(pos_code)
                                           : 8'h00;
        next_neg_switch    = next_power_on ? source_switches(neg_code)
                                           : 8'h00;
    end

    // ------------------------------------------------------------------
    // Registered switch state
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            power_on      <= 1'b0;
            high_speed    <= 1'b0;
            buffer_on     <= 1'b0;
            general_on    <= 1'b0;
            pga_on        <= 1'b0;
            pga_inverting <= 1'b0;
            pos_switch    <= 8'h00;
            neg_switch    <= 8'h00;
        end else begin
            power_on      <= next_power_on;
            high_speed    <= next_high_speed;
            buffer_on     <= next_buffer_on;
            general_on    <= next_general_on;
            pga_on        <= next_pga_on;
            pga_inverting <= next_pga_inverting;
            pos_switch    <= next_pos_switch;
            neg_switch    <= next_neg_switch;
        end
    end

endmodule // amp_switch_decode

`default_nettype wire

// ===== dv/amp_ctrl_props.sv
/*
 * Checker for the amplifier control register bank, bound to its top.
 * Assumes one AHB-Lite master and zero wait states from the slave.
 */
`timescale 1ns/10ps
`default_nettype none

module amp_ctrl_props
    import amp_ctrl_pkg::*;
#(
    parameter int ADDR_W = ADDR_WIDTH
)
(
    input wire logic              CLK,
    input wire logic              RST,
    input wire logic              HSEL,
    input wire logic [ADDR_W-1:0] HADDR,
    input wire logic [1:0]        HTRANS,
    input wire logic              HWRITE,
    input wire logic [2:0]        HSIZE,
    input wire logic [31:0]       HWDATA,
    input wire logic              HREADY,
    input wire logic [2:0]        POWER_MODE,
    input wire logic [31:0]       HRDATA,
    input wire logic              HREADYOUT,
    input wire logic              HRESP,
    input wire logic              AMP_POWER_ON,
    input wire logic              AMP_HIGH_SPEED,
    input wire logic              AMP_BUFFER_ON,
    input wire logic              AMP_GENERAL_ON,
    input wire logic              AMP_PGA_ON,
    input wire logic              AMP_PGA_INVERTING,
    input wire logic [2:0]        FEEDBACK_RESISTOR_CODE,
    input wire logic [1:0]        INPUT_RESISTOR_CODE,
    input wire logic [7:0]        POS_SWITCH,
    input wire logic [7:0]        NEG_SWITCH
);
    // ------------------------------------------------------------------
    // Shadow of the three control registers
    // ------------------------------------------------------------------
    logic       taken;
    logic       wr_pend;
    logic [7:0] wr_idx;
    logic [7:0] c0;
    logic [7:0] c1;
    logic [7:0] c2;
    logic [7:0] rd_exp;

    // Word transfer accepted in the address phase
    assign taken = HSEL && HREADY && HTRANS == HTRANS_NONSEQ &&
                   HADDR[1:0] == 2'h0 && HSIZE == 3'h2;

    // Expected read value for the addressed index
    always_comb begin
        case (HADDR[9:2])
            IDX_ENABLE_MODE: rd_exp = c0;
            IDX_GAIN:        rd_exp = c1;
            IDX_INPUT:       rd_exp = c2;
            IDX_POWER_STAT:  rd_exp = {7'h00, AMP_POWER_ON};
            default:         rd_exp = 8'h00;
        endcase
    end

    // Write lands at the end of its data phase
    always_ff @(posedge CLK) begin
        if (RST) begin
            wr_pend <= 1'b0;
            wr_idx  <= 8'h00;
            c0      <= 8'h00;
            c1      <= 8'h00;
            c2      <= 8'h00;
        end else begin
            wr_pend <= taken && HWRITE;
            wr_idx  <= HADDR[9:2];
            if (wr_pend && wr_idx == IDX_ENABLE_MODE)
                c0 <= HWDATA[7:0] & MASK_ENABLE_MODE;
            if (wr_pend && wr_idx == IDX_GAIN)
                c1 <= HWDATA[7:0] & MASK_GAIN;
            if (wr_pend && wr_idx == IDX_INPUT)
                c2 <= HWDATA[7:0] & MASK_INPUT;
        end
    end

    // One-hot switch set, all open for the reserved code or power off
    function automatic logic [7:0] sw(input logic [2:0] c, input logic on);
        return (on && c != 3'h3) ? (8'h01 << c) : 8'h00;
    endfunction

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    AST_RESP: assert property (@(posedge CLK) disable iff (RST)
        HREADYOUT && !HRESP) else $error("slave not ready or not OKAY");
    AST_READ: assert property (@(posedge CLK) disable iff (RST)
        taken && !HWRITE |=> HRDATA == {24'h00_0000, $past(rd_exp)})
        else $error("read data wrong");
    AST_HOLD: assert property (@(posedge CLK) disable iff (RST)
        !$past(taken && !HWRITE) |-> $stable(HRDATA))
        else $error("read data moved without a read");
    AST_POWER: assert property (@(posedge CLK) disable iff (RST)
        AMP_POWER_ON == $past(c0[7] && POWER_MODE != PM_STOP2 &&
                              POWER_MODE != PM_STOP1))
        else $error("power state wrong");
    AST_SPEED: assert property (@(posedge CLK) disable iff (RST)
        AMP_HIGH_SPEED == (AMP_POWER_ON && !$past(c0[6])))
        else $error("speed select wrong");
    AST_MODE: assert property (@(posedge CLK) disable iff (RST)
        {AMP_BUFFER_ON, AMP_GENERAL_ON, AMP_PGA_ON, AMP_PGA_INVERTING} ==
        ({4{AMP_POWER_ON}} & {$past(c0[1:0]) == 2'h0, $past(c0[1:0]) == 2'h2,
                              $past(c0[0]), $past(c0[1:0]) == 2'h1}))
        else $error("configuration decode wrong");
    AST_GAIN: assert property (@(posedge CLK) disable iff (RST)
        {FEEDBACK_RESISTOR_CODE, INPUT_RESISTOR_CODE} == $past(c1[4:0]))
        else $error("gain codes wrong");
    AST_POS: assert property (@(posedge CLK) disable iff (RST)
        POS_SWITCH == sw($past(c2[6:4]), AMP_POWER_ON))
        else $error("positive switch wrong");
    AST_NEG: assert property (@(posedge CLK) disable iff (RST)
        NEG_SWITCH == sw($past(c2[2:0]), AMP_POWER_ON))
        else $error("negative switch wrong");

endmodule // amp_ctrl_props

bind amp_ctrl_regs amp_ctrl_props #(.ADDR_W(ADDR_W)) amp_ctrl_props_i (
    .CLK, .RST, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA, .HREADY,
    .POWER_MODE, .HRDATA, .HREADYOUT, .HRESP, .AMP_POWER_ON, .AMP_HIGH_SPEED,
    .AMP_BUFFER_ON, .AMP_GENERAL_ON, .AMP_PGA_ON, .AMP_PGA_INVERTING,
    .FEEDBACK_RESISTOR_CODE, .INPUT_RESISTOR_CODE, .POS_SWITCH, .NEG_SWITCH);

`default_nettype wire

// ===== dv/tb_top.sv
/*
 * Self-checking bench for the amplifier control register bank.
 * Assumes the single slave's HREADYOUT drives the bus HREADY.
 */
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    import amp_ctrl_pkg::*;
    // ------------------------------------------------------------------
    // Signals and instance
    // ------------------------------------------------------------------
    logic                  CLK = 1'b0;
    logic                  RST, HSEL, HWRITE;
    logic [ADDR_WIDTH-1:0] HADDR;
    logic [1:0]            HTRANS;
    logic [2:0]            HSIZE, POWER_MODE;
    logic [31:0]           HWDATA, HRDATA;
    wire logic             HREADY;
    logic                  HREADYOUT, HRESP, on, hs, bf, gp, pg, iv;
    logic [2:0]            fb;
    logic [1:0]            ir;
    logic [7:0]            ps, ns;
    int                    mismatches = 0;
    int                    checks = 0;
    int                    cycles = 0;

    assign HREADY = HREADYOUT;
    always #5 CLK = ~CLK;

    amp_ctrl_regs amp_ctrl_regs_i (.CLK, .RST, .HSEL, .HADDR, .HTRANS,
        .HWRITE, .HSIZE, .HWDATA, .HREADY, .POWER_MODE, .HRDATA, .HREADYOUT,
        .HRESP, .AMP_POWER_ON(on), .AMP_HIGH_SPEED(hs), .AMP_BUFFER_ON(bf),
        .AMP_GENERAL_ON(gp), .AMP_PGA_ON(pg), .AMP_PGA_INVERTING(iv),
        .FEEDBACK_RESISTOR_CODE(fb), .INPUT_RESISTOR_CODE(ir),
        .POS_SWITCH(ps), .NEG_SWITCH(ns));

    // Hang guard
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            tally_and_finish();
        end
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic tally_and_finish();
        $display("mismatches %0d checks %0d", mismatches, checks);
        if (mismatches == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One AHB-Lite single word transfer
    task automatic bus(input logic [11:0] a, input logic w,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge CLK);
        HSEL <= 1'b1;
        HTRANS <= HTRANS_NONSEQ;
        HADDR <= a;
        HWRITE <= w;
        do @(posedge CLK); while (HREADY !== 1'b1);
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= wd;
        do @(posedge CLK); while (HREADY !== 1'b1);
        rd = HRDATA;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        bus(a, 1'b1, d, rd);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        bus(a, 1'b0, 32'h0000_0000, rd);
        chk(rd, exp);
    endtask

    // Expected switch set
    function automatic logic [7:0] sw(input logic [2:0] c, input logic e);
        return (e && c != 3'h3) ? (8'h01 << c) : 8'h00;
    endfunction

    // Compare all amplifier outputs once they have settled
    task automatic out_chk(input logic e, input logic lp, input logic [1:0] m,
                           input logic [4:0] g, input logic [2:0] p, n);
        repeat (2) @(posedge CLK);
        #1;
        chk({5'h00, on, hs, bf, gp, pg, iv, fb, ir, ps, ns},
            {5'h00, e, e && !lp, {4{e}} & {m == 2'h0, m == 2'h2, m[0],
             m == 2'h1}, g, sw(p, e), sw(n, e)});
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        rd_chk(12'h000, 32'h0000_0000);
        rd_chk(12'h004, 32'h0000_0000);
        rd_chk(12'h008, 32'h0000_0000);
        out_chk(1'b0, 1'b0, 2'h0, 5'h00, 3'h0, 3'h0);
    endtask

    task automatic t_access();
        wr(12'h000, 32'hFFFF_FFFF);
        wr(12'h004, 32'hFFFF_FFFF);
        wr(12'h008, 32'hFFFF_FFFF);
        wr(12'h010, 32'hFFFF_FFFF);
        wr(12'h001, 32'h0000_0000);
        HSIZE <= 3'h0;
        wr(12'h000, 32'h0000_0000);
        HSIZE <= 3'h2;
        rd_chk(12'h000, 32'h0000_00C3);
        rd_chk(12'h004, 32'h0000_001F);
        rd_chk(12'h008, 32'h0000_0077);
        rd_chk(12'h010, 32'h0000_0000);
        rd_chk(12'h00C, 32'h0000_0001);
        out_chk(1'b1, 1'b1, 2'h3, 5'h1F, 3'h7, 3'h7);
    endtask

    task automatic t_power();
        wr(12'h000, 32'h0000_0080);
        for (int e = 1; e >= 0; e--) begin
            for (int m = 0; m < 5; m++) begin
                @(posedge CLK);
                POWER_MODE <= 3'(m);
                out_chk(e == 1 && m < 3, 1'b0, 2'h0, 5'h1F, 3'h7, 3'h7);
            end
            POWER_MODE <= PM_RUN;
            wr(12'h000, 32'h0000_0000);
        end
        out_chk(1'b0, 1'b0, 2'h0, 5'h1F, 3'h7, 3'h7);
    endtask

    task automatic t_modes();
        for (int i = 0; i < 8; i++) begin
            wr(12'h000, 32'h0000_0080 | ((i & 1) << 6) | (i >> 1));
            out_chk(1'b1, 1'(i), 2'(i >> 1), 5'h1F, 3'h7, 3'h7);
        end
    endtask

    task automatic t_select();
        for (int c = 0; c < 8; c++) begin
            wr(12'h004, 32'((c << 2) | (c & 3)));
            wr(12'h008, 32'((c << 4) | (7 - c)));
            out_chk(1'b1, 1'b1, 2'h3, 5'((c << 2) | (c & 3)), 3'(c),
                    3'(7 - c));
        end
    endtask

    // Reset, then the scenarios in order
    initial begin
        RST = 1'b1;
        HSEL = 1'b0;
        HWRITE = 1'b0;
        HADDR = '0;
        HTRANS = 2'h0;
        HSIZE = 3'h2;
        POWER_MODE = PM_RUN;
        HWDATA = 32'h0000_0000;
        repeat (10) @(posedge CLK);
        RST <= 1'b0;
        t_reset();
        t_access();
        t_power();
        t_modes();
        t_select();
        tally_and_finish();
    end

endmodule // tb_top

`default_nettype wire
